// *** cvd_ctrl.sv ***
// Purpose: line and frame sequencer driving sensor vertical timing
// Assumes: one system clock stands in for the line clock
// Notes: analogue drive levels are outside this logic
`timescale 1ns/1ps
module cvd_ctrl #(
    parameter int LINES_FRAME_NTSC = 1828,
    parameter int LINES_FRAME_PAL = 1890,
    parameter int LINES_HR_NTSC = 263,
    parameter int LINES_HR_PAL = 315,
    parameter int LINES_F1_NTSC = 182,
    parameter int LINES_F1_PAL = 158,
    parameter int LINES_F2_NTSC = 66,
    parameter int LINES_F2_PAL = 79,
    parameter int BIAS_LEAD = cvd_pkg::BIAS_LEAD_CYC,
    parameter int SWEEP_LINES = 780
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] mode_i,
    input wire logic pal_i,
    input wire logic mech_shutter_i,
    input wire logic expose_req_i,
    input wire logic shutter_closed_i,
    input wire logic [7:0] shift_lines_i,
    output logic line_start_o,
    output logic frame_start_o,
    output logic [11:0] line_o,
    output logic bias_ctrl_o,
    output logic expose_o,
    output logic sweep_o,
    output logic readout_o,
    output logic shift_o,
    output logic video_valid_o
);
    typedef enum logic [2:0] {ST_RUN, ST_LEAD, ST_EXPOSE, ST_SWEEP, ST_READ} cvd_seq_t;
    logic rst_a_r, rst_b_r;
    logic [2:0] exp_sy_r, clo_sy_r;
    logic [11:0] clk_cnt_r, line_cnt_r, line_len, frame_len, out_start;
    logic line_end, frame_end;
    logic [31:0] lead_cnt_r;
    logic [11:0] sweep_cnt_r;
    logic [7:0] shift_cnt_r;
    cvd_seq_t seq_r;
    cvd_pkg::cvd_mode_t mode;

    assign mode = cvd_pkg::cvd_mode_t'({1'b0, mode_i});

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end

    // pins come from the camera side, synchronise before use
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            exp_sy_r <= 3'h0;
            clo_sy_r <= 3'h0;
        end else begin
            exp_sy_r <= {exp_sy_r[1:0], expose_req_i};
            clo_sy_r <= {clo_sy_r[1:0], shutter_closed_i};
        end
    end

    always_comb begin
        line_len = cvd_pkg::LINE_CLKS;
        frame_len = 12'(LINES_FRAME_NTSC);
        out_start = 12'h000;
        case (mode)
            cvd_pkg::CVD_FRAME: begin
                frame_len = pal_i ? 12'(LINES_FRAME_PAL) : 12'(LINES_FRAME_NTSC);
                if (!pal_i && (line_cnt_r == cvd_pkg::FR_NTSC_LINE_A || line_cnt_r == cvd_pkg::FR_NTSC_LINE_B))
                    line_len = cvd_pkg::FR_NTSC_SHORT;
                if (pal_i && (line_cnt_r == cvd_pkg::FR_PAL_LINE_A || line_cnt_r == cvd_pkg::FR_PAL_LINE_B ||
                        line_cnt_r == cvd_pkg::FR_PAL_LINE_C || line_cnt_r == cvd_pkg::FR_PAL_LINE_D))
                    line_len = cvd_pkg::FR_PAL_SHORT;
            end
            cvd_pkg::CVD_HIGH_RATE: begin
                frame_len = pal_i ? 12'(LINES_HR_PAL) : 12'(LINES_HR_NTSC);
                if (!pal_i && line_cnt_r == cvd_pkg::HR_NTSC_LINE)
                    line_len = cvd_pkg::HR_NTSC_SHORT;
                if (pal_i && line_cnt_r == cvd_pkg::HR_PAL_LINE)
                    line_len = cvd_pkg::HR_PAL_SHORT;
            end
            cvd_pkg::CVD_FOCUS_ONE: begin
                frame_len = pal_i ? 12'(LINES_F1_PAL) : 12'(LINES_F1_NTSC);
                out_start = cvd_pkg::F1_OUT_START;
                if (!pal_i && line_cnt_r == cvd_pkg::F1_NTSC_LINE)
                    line_len = cvd_pkg::F1_NTSC_SHORT;
                if (pal_i && line_cnt_r == cvd_pkg::F1_PAL_LINE)
                    line_len = cvd_pkg::F1_PAL_SHORT;
            end
            cvd_pkg::CVD_FOCUS_TWO: begin
                frame_len = pal_i ? 12'(LINES_F2_PAL) : 12'(LINES_F2_NTSC);
                out_start = cvd_pkg::F2_OUT_START;
                if (!pal_i && line_cnt_r == cvd_pkg::F2_NTSC_LINE)
                    line_len = cvd_pkg::F2_NTSC_SHORT;
                if (pal_i && line_cnt_r == cvd_pkg::F2_PAL_LINE)
                    line_len = cvd_pkg::F2_PAL_SHORT;
            end
            default: line_len = cvd_pkg::LINE_CLKS;
        endcase
    end

    assign line_end = (clk_cnt_r >= line_len - 12'h001);
    assign frame_end = line_end && (line_cnt_r >= frame_len);

    // lines count from 1 as on the timing charts
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            clk_cnt_r <= 12'h000;
            line_cnt_r <= 12'h001;
        end else if (line_end) begin
            clk_cnt_r <= 12'h000;
            line_cnt_r <= frame_end ? 12'h001 : line_cnt_r + 12'h001;
        end else begin
            clk_cnt_r <= clk_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            line_start_o <= 1'b0;
            frame_start_o <= 1'b0;
            line_o <= 12'h000;
        end else begin
            line_start_o <= line_end;
            frame_start_o <= frame_end;
            line_o <= line_cnt_r;
        end
    end

    // frame shift burst at frame start in the two focus modes, then output window
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            shift_cnt_r <= 8'h00;
            shift_o <= 1'b0;
            video_valid_o <= 1'b0;
        end else begin
            if (frame_end && (mode == cvd_pkg::CVD_FOCUS_ONE || mode == cvd_pkg::CVD_FOCUS_TWO))
                shift_cnt_r <= shift_lines_i;
            else if (line_end && shift_cnt_r != 8'h00)
                shift_cnt_r <= shift_cnt_r - 8'h01;
            shift_o <= (shift_cnt_r != 8'h00);
            video_valid_o <= (line_cnt_r >= out_start) && (line_cnt_r <= frame_len);
        end
    end

    // shutter sequence; lead count is long, shorten via parameter in sim
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            seq_r <= ST_RUN;
            lead_cnt_r <= 32'h0000_0000;
            sweep_cnt_r <= 12'h000;
            bias_ctrl_o <= 1'b0;
            expose_o <= 1'b0;
            sweep_o <= 1'b0;
            readout_o <= 1'b0;
        end else begin
            case (seq_r)
                ST_RUN: begin
                    bias_ctrl_o <= 1'b0;
                    readout_o <= 1'b0;
                    if (mech_shutter_i && exp_sy_r[2]) begin
                        seq_r <= ST_LEAD;
                        lead_cnt_r <= 32'h0000_0000;
                        bias_ctrl_o <= 1'b1;
                    end
                end
                ST_LEAD: begin
                    lead_cnt_r <= lead_cnt_r + 32'h0000_0001;
                    if (lead_cnt_r >= 32'(BIAS_LEAD - 1)) begin
                        seq_r <= ST_EXPOSE;
                        expose_o <= 1'b1;
                    end
                end
                ST_EXPOSE: begin
                    if (clo_sy_r[2]) begin
                        seq_r <= ST_SWEEP;
                        expose_o <= 1'b0;
                        sweep_o <= 1'b1;
                        sweep_cnt_r <= 12'h000;
                    end
                end
                ST_SWEEP: begin
                    // a full field of idle lines clears blooming charge
                    // first line is partial, so wait for that many whole lines after it
                    if (line_end)
                        sweep_cnt_r <= sweep_cnt_r + 12'h001;
                    if (line_end && sweep_cnt_r >= 12'(SWEEP_LINES)) begin
                        seq_r <= ST_READ;
                        sweep_o <= 1'b0;
                        readout_o <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (frame_end) begin
                        seq_r <= ST_RUN;
                        readout_o <= 1'b0;
                        bias_ctrl_o <= 1'b0;
                    end
                end
                default: seq_r <= ST_RUN;
            endcase
        end
    end
endmodule

// *** cvd_pkg.sv ***
// Purpose: constants for the vertical drive timing controller
// Assumes: one line clock, counts in line-clock units
// Notes: frame lengths are derived from standard line counts
package cvd_pkg;
    typedef enum logic [2:0] {
        CVD_FRAME,
        CVD_HIGH_RATE,
        CVD_FOCUS_ONE,
        CVD_FOCUS_TWO
    } cvd_mode_t;
    localparam logic [11:0] LINE_CLKS = 12'h8F0;
    localparam logic [11:0] FR_NTSC_SHORT = 12'h6B4;
    localparam logic [11:0] FR_NTSC_LINE_A = 12'h397;
    localparam logic [11:0] FR_NTSC_LINE_B = 12'h724;
    localparam logic [11:0] FR_PAL_SHORT = 12'h4B8;
    localparam logic [11:0] FR_PAL_LINE_A = 12'h3B0;
    localparam logic [11:0] FR_PAL_LINE_B = 12'h3B1;
    localparam logic [11:0] FR_PAL_LINE_C = 12'h761;
    localparam logic [11:0] FR_PAL_LINE_D = 12'h762;
    localparam logic [11:0] HR_NTSC_SHORT = 12'h478;
    localparam logic [11:0] HR_NTSC_LINE = 12'h107;
    localparam logic [11:0] HR_PAL_SHORT = 12'h620;
    localparam logic [11:0] HR_PAL_LINE = 12'h13B;
    localparam logic [11:0] F1_NTSC_SHORT = 12'h23C;
    localparam logic [11:0] F1_NTSC_LINE = 12'h0B6;
    localparam logic [11:0] F1_PAL_SHORT = 12'h310;
    localparam logic [11:0] F1_PAL_LINE = 12'h09E;
    localparam logic [11:0] F2_NTSC_SHORT = 12'h596;
    localparam logic [11:0] F2_NTSC_LINE = 12'h042;
    localparam logic [11:0] F2_PAL_SHORT = 12'h54C;
    localparam logic [11:0] F2_PAL_LINE = 12'h04F;
    localparam logic [11:0] F1_OUT_START = 12'h01A;
    localparam logic [11:0] F2_OUT_START = 12'h01E;
    localparam int BIAS_LEAD_MS = 40;
    localparam int CLK_HZ = 50000000;
    localparam int BIAS_LEAD_CYC = (BIAS_LEAD_MS * (CLK_HZ / 1000));
endpackage

// *** cvd_chk.sv ***
// Purpose: port checks for the vertical drive sequencer
// Assumes: mode and standard change only in reset
// Notes: exception lines are only reached on full frames
`timescale 1ns/1ps
module cvd_chk #(
    parameter int BIAS_LEAD = 20,
    parameter int SWEEP_LINES = 2
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] mode_i,
    input wire logic pal_i,
    input wire logic mech_shutter_i,
    input wire logic line_start_o,
    input wire logic frame_start_o,
    input wire logic [11:0] line_o,
    input wire logic bias_ctrl_o,
    input wire logic expose_o,
    input wire logic sweep_o,
    input wire logic readout_o,
    input wire logic shift_o
);
    logic [11:0] lc_r;
    logic seen_r;
    int bc_r;
    int swc_r;
    function automatic logic [11:0] elen(input logic [2:0] s, input logic [11:0] l);
        case (s)
            3'h0: return (l == 12'h397 || l == 12'h724) ? 12'h6B4 : 12'h8F0;
            3'h1: return (l inside {12'h3B0, 12'h3B1, 12'h761, 12'h762}) ? 12'h4B8 : 12'h8F0;
            3'h2: return (l == 12'h107) ? 12'h478 : 12'h8F0;
            3'h3: return (l == 12'h13B) ? 12'h620 : 12'h8F0;
            3'h4: return (l == 12'h0B6) ? 12'h23C : 12'h8F0;
            3'h5: return (l == 12'h09E) ? 12'h310 : 12'h8F0;
            3'h6: return (l == 12'h042) ? 12'h596 : 12'h8F0;
            default: return (l == 12'h04F) ? 12'h54C : 12'h8F0;
        endcase
    endfunction
    // first line after reset is not measured, its start is unknown
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lc_r <= 12'h000;
            seen_r <= 1'b0;
            bc_r <= 0;
            swc_r <= 0;
        end else begin
            lc_r <= line_start_o ? 12'h001 : lc_r + 12'h001;
            seen_r <= seen_r | line_start_o;
            bc_r <= bias_ctrl_o ? bc_r + 1 : 0;
            swc_r <= expose_o ? 0 : swc_r + int'(line_start_o && !readout_o);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_LINE_LEN: assert property (line_start_o && seen_r |-> lc_r == elen({mode_i, pal_i}, line_o))
        else $error("line length wrong");
    AST_LINE_PULSE: assert property (line_start_o |=> !line_start_o [*8])
        else $error("line pulse too long");
    AST_FRAME_LINE: assert property (frame_start_o |-> line_start_o)
        else $error("frame start off a line boundary");
    AST_BIAS_LEAD: assert property ($rose(expose_o) |-> bc_r >= BIAS_LEAD)
        else $error("bias lead too short");
    AST_EXPOSE_BIAS: assert property (expose_o |-> bias_ctrl_o)
        else $error("exposure without bias");
    AST_NO_BIAS: assert property (!mech_shutter_i |-> !bias_ctrl_o)
        else $error("bias grounded without shutter");
    AST_SWEEP_READ: assert property (sweep_o |-> !readout_o)
        else $error("sweep overlaps readout");
    AST_READ_SWEPT: assert property ($rose(readout_o) |-> swc_r + int'(line_start_o) > SWEEP_LINES)
        else $error("readout before full sweep");
    AST_SHIFT_MODE: assert property (shift_o |-> mode_i[1])
        else $error("frame shift outside focus modes");
endmodule
bind cvd_ctrl cvd_chk #(.BIAS_LEAD(BIAS_LEAD), .SWEEP_LINES(SWEEP_LINES)) u_chk (.ref_clk_i, .nrst_i, .mode_i,
    .pal_i, .mech_shutter_i, .line_start_o, .frame_start_o, .line_o, .bias_ctrl_o, .expose_o, .sweep_o,
    .readout_o, .shift_o);

// *** cvd_shutter_model.sv ***
// Purpose: sensor side stand-in with a mechanical shutter
// Assumes: shutter closes a fixed time into exposure
// Notes: stays closed until reset, as after a still capture
`timescale 1ns/1ps
module cvd_shutter_model #(
    parameter int EXP_CYC = 30
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic expose_i,
    output logic closed_o
);
    int cnt_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 0;
            closed_o <= 1'b0;
        end else begin
            cnt_r <= expose_i ? cnt_r + 1 : cnt_r;
            closed_o <= closed_o | (cnt_r >= EXP_CYC);
        end
    end
endmodule

// *** cvd_ctrl_tb.sv ***
// Purpose: self-checking bench for the vertical drive sequencer
// Assumes: two-line frames, short bias lead and sweep
// Notes: exception line lengths are left to the checker
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    $display("BAD %s exp %0h got %0h", nm, e, g); n_fail++; end end
module cvd_ctrl_tb;
    localparam int NL = 2;
    localparam int LIM = 20000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode = 2'h0;
    logic pal = 1'b0;
    logic mech = 1'b0;
    logic req = 1'b0;
    logic [7:0] shift = 8'h00;
    logic closed, line_start, frame_start, bias, expose, sweep, readout;
    logic valid, shifting;
    logic [11:0] line;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 33;
    int n = 0;
    int cnt = 0;
    wire [4:0] obs = {readout, sweep, expose, bias, frame_start};
    cvd_ctrl #(.LINES_FRAME_NTSC(NL), .LINES_FRAME_PAL(NL), .LINES_HR_NTSC(NL), .LINES_HR_PAL(NL),
        .LINES_F1_NTSC(NL), .LINES_F1_PAL(NL), .LINES_F2_NTSC(NL), .LINES_F2_PAL(NL),
        .BIAS_LEAD(20), .SWEEP_LINES(2)) u_dut (.ref_clk_i(clk), .nrst_i(nrst), .mode_i(mode), .pal_i(pal),
        .mech_shutter_i(mech), .expose_req_i(req), .shutter_closed_i(closed), .shift_lines_i(shift),
        .line_start_o(line_start), .frame_start_o(frame_start), .line_o(line), .bias_ctrl_o(bias),
        .expose_o(expose), .sweep_o(sweep), .readout_o(readout), .shift_o(shifting), .video_valid_o(valid));
    cvd_shutter_model #(.EXP_CYC(30)) u_shut (.clk_i(clk), .nrst_i(nrst), .expose_i(expose), .closed_o(closed));
    function automatic int frame_len(input int nl);
        return nl * 32'h8F0;
    endfunction
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic end_of_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // mode changes only under reset, the sequencer has no clean switch
    task automatic restart(input logic [4:0] cfg);
        @(negedge clk);
        {mode, pal, mech, req} = cfg;
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
    endtask
    task automatic wt(input int b);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            cnt += int'(line_start);
        end while (obs[b] !== 1'b1 && n < LIM);
        if (n >= LIM) begin
            n_fail++;
            end_of_test;
        end
    endtask
    initial begin
        for (int k = 0; k < 8; k++) begin
            shift = 8'($random(seed));
            restart({3'(k), 1'b0, 1'($random(seed))});
            wt(0);
            cnt = 0;
            wt(0);
            `CHK("frame_cyc", frame_len(NL), n)
            `CHK("lines", NL, cnt)
            `CHK("bias_idle", 1'b0, bias)
            // two-line frames never reach the focus output start line
            `CHK("video_valid", !mode[1], valid)
            // one line shifted before the reload at frame end
            `CHK("shift_busy", mode[1] && shift > 8'h01, shifting)
        end
        restart(5'h02);
        repeat (3) @(negedge clk);
        req = 1'b1;
        wt(1);
        wt(2);
        `CHK("bias_lead", 20, n)
        wt(3);
        `CHK("expose_end", 1'b0, expose)
        cnt = 0;
        wt(4);
        // partial first line plus two whole swept lines
        `CHK("sweep_lines", 3, cnt)
        `CHK("sweep_off", 1'b0, sweep)
        req = 1'b0;
        wt(0);
        `CHK("done", 2'h0, {readout, bias})
        end_of_test;
    end
endmodule
